// [pkg/acmp_pkg.sv]
// constants, field layouts and carrier types of the analog comparator control
// Functional notes
// - result is one when selected positive input exceeds selected negative input
// - mux enabled and converter off: channel code 0..7 picks converter pin 0..7
// - mux disabled or converter on: dedicated negative pin is the negative input
// - bandgap select one feeds bandgap to positive input, else positive pin
// - raw result is synchronised before the read-only result bit, 1-2 cycles
// - event flag sets on the edge type chosen by the mode bits
// - mode 00 toggle, 10 falling, 11 rising, 01 reserved
// - event flag clears when the processor executes the comparator vector
// - writing one to the flag clears it, writing zero leaves it
// - irq asserted while flag, comparator irq enable and global enable are set
// - disable bit one powers comparator off any time, zero restores it
// - capture enable routes result to timer capture front end, else none
// - pin input-off bit disables that buffer and its pin read returns zero
// - converter reg B: bit 6 mux enable, bits 2:0 trigger select, rest zero
package acmp_pkg;
	localparam int AXI_AW = 12;
	localparam int AXI_DW = 32;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_ADC_CTRL_B = 8'h7B;
	localparam logic [7:0] IDX_CMP_CTRL = 8'h50;
	localparam logic [7:0] IDX_PIN_OFF = 8'h7E;
	localparam logic [7:0] ADC_CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
	localparam logic [7:0] PIN_OFF_RESET = 8'h00;
	localparam int ADCB_MUX_EN_BIT = 6;
	localparam int ADCB_TRIG_LSB = 0;
	localparam int TRIG_W = 3;
	localparam int CMP_DISABLE_BIT = 7;
	localparam int CMP_BANDGAP_BIT = 6;
	localparam int CMP_RESULT_BIT = 5;
	localparam int CMP_FLAG_BIT = 4;
	localparam int CMP_IRQ_EN_BIT = 3;
	localparam int CMP_CAPTURE_BIT = 2;
	localparam int CMP_MODE_LSB = 0;
	localparam int PIN_NEG_OFF_BIT = 1;
	localparam int PIN_POS_OFF_BIT = 0;
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int SYNC_STAGES = 2;
	localparam int CONV_PINS = 8;

	typedef struct packed {
		logic [AXI_AW-1:0] awaddr;
		logic awvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [AXI_AW-1:0] araddr;
		logic arvalid;
		logic rready;
	} acmp_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} acmp_axil_rsp_t;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stage;
	} acmp_sync_st_t;
endpackage

// [hdl/acmp_sync.sv]
// two-stage synchroniser for the raw comparator result
`timescale 1ns/1ps
`default_nettype none
module acmp_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic raw_in,
	output logic sync_out
);
	acmp_pkg::acmp_sync_st_t st_reg;
	acmp_pkg::acmp_sync_st_t st_next;

	// only the last stage is read outside the chain
	always_comb begin
		st_next = st_reg;
		st_next.stage = {st_reg.stage[acmp_pkg::SYNC_STAGES-2:0], raw_in};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.stage[acmp_pkg::SYNC_STAGES-1];
endmodule // acmp_sync
`default_nettype wire

// [hdl/acmp_input_mux.sv]
// input selection and comparison of the comparator inputs
`timescale 1ns/1ps
`default_nettype none
module acmp_input_mux #(
	parameter int LEVEL_W = 10,
	parameter logic [LEVEL_W-1:0] BANDGAP_LEVEL = '1 >> 1
) (
	input wire logic [LEVEL_W-1:0] positive_compare_pin,
	input wire logic [LEVEL_W-1:0] negative_compare_pin,
	input wire logic [acmp_pkg::CONV_PINS*LEVEL_W-1:0] converter_pins,
	input wire logic bandgap_select,
	input wire logic negative_mux_enable,
	input wire logic converter_enable,
	input wire logic [acmp_pkg::TRIG_W-1:0] channel_select_low,
	input wire logic comparator_disable,
	output logic raw_result
);
	logic [LEVEL_W-1:0] pos_level;
	logic [LEVEL_W-1:0] neg_level;

	always_comb begin
		pos_level = bandgap_select ? BANDGAP_LEVEL : positive_compare_pin;
		if (negative_mux_enable && !converter_enable) begin
			neg_level = converter_pins[channel_select_low*LEVEL_W +: LEVEL_W];
		end else begin
			neg_level = negative_compare_pin;
		end
		// a powered-off comparator holds its output low
		raw_result = !comparator_disable && (pos_level > neg_level);
	end
endmodule // acmp_input_mux
`default_nettype wire

// [hdl/acmp_ctrl.sv]
// analog comparator control: register slave, event flag, irq and routing
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acmp_ctrl #(
	parameter int LEVEL_W = 10,
	parameter logic [LEVEL_W-1:0] BANDGAP_LEVEL = '1 >> 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire acmp_pkg::acmp_axil_req_t axil_req,
	output acmp_pkg::acmp_axil_rsp_t axil_rsp,
	input wire logic [LEVEL_W-1:0] positive_compare_pin,
	input wire logic [LEVEL_W-1:0] negative_compare_pin,
	input wire logic [acmp_pkg::CONV_PINS*LEVEL_W-1:0] converter_pins,
	input wire logic converter_enable,
	input wire logic [acmp_pkg::TRIG_W-1:0] channel_select_low,
	input wire logic global_irq_enable,
	input wire logic irq_vector_ack,
	input wire logic [1:0] pin_digital_in,
	output logic compare_irq,
	output logic capture_trigger,
	output logic [1:0] pin_read_value,
	output logic [1:0] pin_buffer_enable,
	output logic comparator_power_on,
	output logic bandgap_select,
	output logic negative_mux_enable,
	output logic [acmp_pkg::TRIG_W-1:0] trigger_source_select
);
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
		logic aw_got;
		logic w_got;
		logic [acmp_pkg::AXI_AW-1:0] awaddr;
		logic [7:0] wbyte;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rbyte;
		logic mux_en;
		logic [acmp_pkg::TRIG_W-1:0] trig_sel;
		logic cmp_dis;
		logic bg_sel;
		logic flag;
		logic irq_en;
		logic capt_en;
		logic [1:0] mode;
		logic neg_off;
		logic pos_off;
		logic result_prev;
		logic irq;
		logic capture;
		logic [1:0] pin_read;
		logic [1:0] buf_en;
		logic pwr_on;
	} acmp_ctrl_st_t;

	acmp_ctrl_st_t st_reg;
	acmp_ctrl_st_t st_next;

	logic raw_result;
	logic result_sync;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic wr_do;
	logic rising;
	logic falling;
	logic event_hit;
	logic flag_clr;
	logic [7:0] cmp_view;
	logic [7:0] adcb_view;
	logic [7:0] pin_view;

	// byte address of a register index
	function automatic logic [acmp_pkg::AXI_AW-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = acmp_pkg::AXI_AW'({idx, 2'b00});
	endfunction

	// decode of a word address, used by both the read and the write path
	function automatic logic [1:0] decode(input logic [acmp_pkg::AXI_AW-1:0] addr);
		logic [acmp_pkg::AXI_AW-1:0] word;
		word = addr >> 2;
		if (word == (reg_addr(acmp_pkg::IDX_ADC_CTRL_B) >> 2)) begin
			decode = 2'h1;
		end else if (word == (reg_addr(acmp_pkg::IDX_CMP_CTRL) >> 2)) begin
			decode = 2'h2;
		end else if (word == (reg_addr(acmp_pkg::IDX_PIN_OFF) >> 2)) begin
			decode = 2'h3;
		end else begin
			decode = 2'h0;
		end
	endfunction

	acmp_input_mux #(
		.LEVEL_W(LEVEL_W),
		.BANDGAP_LEVEL(BANDGAP_LEVEL)
	) u_mux (
		.positive_compare_pin(positive_compare_pin),
		.negative_compare_pin(negative_compare_pin),
		.converter_pins(converter_pins),
		.bandgap_select(st_reg.bg_sel),
		.negative_mux_enable(st_reg.mux_en),
		.converter_enable(converter_enable),
		.channel_select_low(channel_select_low),
		.comparator_disable(st_reg.cmp_dis),
		.raw_result(raw_result)
	);

	acmp_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw_in(raw_result),
		.sync_out(result_sync)
	);

	// register images as software sees them
	always_comb begin
		adcb_view = 8'h00;
		adcb_view[acmp_pkg::ADCB_MUX_EN_BIT] = st_reg.mux_en;
		adcb_view[acmp_pkg::ADCB_TRIG_LSB +: acmp_pkg::TRIG_W] = st_reg.trig_sel;
		cmp_view = 8'h00;
		cmp_view[acmp_pkg::CMP_DISABLE_BIT] = st_reg.cmp_dis;
		cmp_view[acmp_pkg::CMP_BANDGAP_BIT] = st_reg.bg_sel;
		cmp_view[acmp_pkg::CMP_RESULT_BIT] = result_sync;
		cmp_view[acmp_pkg::CMP_FLAG_BIT] = st_reg.flag;
		cmp_view[acmp_pkg::CMP_IRQ_EN_BIT] = st_reg.irq_en;
		cmp_view[acmp_pkg::CMP_CAPTURE_BIT] = st_reg.capt_en;
		cmp_view[acmp_pkg::CMP_MODE_LSB +: 2] = st_reg.mode;
		pin_view = 8'h00;
		pin_view[acmp_pkg::PIN_NEG_OFF_BIT] = st_reg.neg_off;
		pin_view[acmp_pkg::PIN_POS_OFF_BIT] = st_reg.pos_off;
	end

	// edge detection on the synchronised result
	always_comb begin
		rising = result_sync && !st_reg.result_prev;
		falling = !result_sync && st_reg.result_prev;
		case (st_reg.mode)
			acmp_pkg::MODE_TOGGLE: event_hit = rising || falling;
			acmp_pkg::MODE_FALL: event_hit = falling;
			acmp_pkg::MODE_RISE: event_hit = rising;
			acmp_pkg::MODE_RESERVED: event_hit = 1'b0;
			default: event_hit = 1'b0;
		endcase
	end

	always_comb begin
		aw_hs = axil_req.awvalid && st_reg.aw_rdy;
		w_hs = axil_req.wvalid && st_reg.w_rdy;
		ar_hs = axil_req.arvalid && st_reg.ar_rdy;
		wr_do = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
		flag_clr = irq_vector_ack;
		if (wr_do && st_reg.wlane && decode(st_reg.awaddr) == 2'h2
			&& st_reg.wbyte[acmp_pkg::CMP_FLAG_BIT]) begin
			flag_clr = 1'b1;
		end
	end

	always_comb begin
		st_next = st_reg;
		// write address and data, taken in either order
		if (aw_hs) begin
			st_next.awaddr = axil_req.awaddr;
			st_next.aw_got = 1'b1;
			st_next.aw_rdy = 1'b0;
		end
		if (w_hs) begin
			st_next.wbyte = axil_req.wdata[7:0];
			st_next.wlane = axil_req.wstrb[0];
			st_next.w_got = 1'b1;
			st_next.w_rdy = 1'b0;
		end
		if (wr_do) begin
			st_next.bvalid = 1'b1;
			st_next.bresp = acmp_pkg::RESP_OKAY;
			case (decode(st_reg.awaddr))
				2'h1: begin
					if (st_reg.wlane) begin
						st_next.mux_en = st_reg.wbyte[acmp_pkg::ADCB_MUX_EN_BIT];
						st_next.trig_sel = st_reg.wbyte[acmp_pkg::ADCB_TRIG_LSB +:
							acmp_pkg::TRIG_W];
					end
				end
				2'h2: begin
					if (st_reg.wlane) begin
						st_next.cmp_dis = st_reg.wbyte[acmp_pkg::CMP_DISABLE_BIT];
						st_next.bg_sel = st_reg.wbyte[acmp_pkg::CMP_BANDGAP_BIT];
						st_next.irq_en = st_reg.wbyte[acmp_pkg::CMP_IRQ_EN_BIT];
						st_next.capt_en = st_reg.wbyte[acmp_pkg::CMP_CAPTURE_BIT];
						st_next.mode = st_reg.wbyte[acmp_pkg::CMP_MODE_LSB +: 2];
					end
				end
				2'h3: begin
					if (st_reg.wlane) begin
						st_next.neg_off = st_reg.wbyte[acmp_pkg::PIN_NEG_OFF_BIT];
						st_next.pos_off = st_reg.wbyte[acmp_pkg::PIN_POS_OFF_BIT];
					end
				end
				default: st_next.bresp = acmp_pkg::RESP_DECERR;
			endcase
		end
		if (st_reg.bvalid && axil_req.bready) begin
			st_next.bvalid = 1'b0;
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.aw_rdy = 1'b1;
			st_next.w_rdy = 1'b1;
		end
		// read channel
		if (ar_hs) begin
			st_next.ar_rdy = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = acmp_pkg::RESP_OKAY;
			case (decode(axil_req.araddr))
				2'h1: st_next.rbyte = adcb_view;
				2'h2: st_next.rbyte = cmp_view;
				2'h3: st_next.rbyte = pin_view;
				default: begin
					st_next.rbyte = 8'h00;
					st_next.rresp = acmp_pkg::RESP_DECERR;
				end
			endcase
		end
		if (st_reg.rvalid && axil_req.rready) begin
			st_next.rvalid = 1'b0;
			st_next.ar_rdy = 1'b1;
		end
		// event flag: a new event wins over any clear in the same cycle
		st_next.result_prev = result_sync;
		if (event_hit) begin
			st_next.flag = 1'b1;
		end else if (flag_clr) begin
			st_next.flag = 1'b0;
		end
		st_next.irq = st_next.flag && st_next.irq_en && global_irq_enable;
		st_next.capture = st_next.capt_en && result_sync;
		st_next.buf_en = ~{st_next.neg_off, st_next.pos_off};
		st_next.pin_read = pin_digital_in & st_next.buf_en;
		st_next.pwr_on = !st_next.cmp_dis;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.aw_rdy <= 1'b1;
			st_reg.w_rdy <= 1'b1;
			st_reg.ar_rdy <= 1'b1;
			st_reg.mux_en <= acmp_pkg::ADC_CTRL_B_RESET[acmp_pkg::ADCB_MUX_EN_BIT];
			st_reg.trig_sel <= acmp_pkg::ADC_CTRL_B_RESET[acmp_pkg::ADCB_TRIG_LSB +:
				acmp_pkg::TRIG_W];
			st_reg.cmp_dis <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_DISABLE_BIT];
			st_reg.pwr_on <= !acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_DISABLE_BIT];
			st_reg.bg_sel <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_BANDGAP_BIT];
			st_reg.flag <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_FLAG_BIT];
			st_reg.irq_en <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_IRQ_EN_BIT];
			st_reg.capt_en <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_CAPTURE_BIT];
			st_reg.mode <= acmp_pkg::CMP_CTRL_RESET[acmp_pkg::CMP_MODE_LSB +: 2];
			st_reg.neg_off <= acmp_pkg::PIN_OFF_RESET[acmp_pkg::PIN_NEG_OFF_BIT];
			st_reg.pos_off <= acmp_pkg::PIN_OFF_RESET[acmp_pkg::PIN_POS_OFF_BIT];
			st_reg.buf_en <= ~{acmp_pkg::PIN_OFF_RESET[acmp_pkg::PIN_NEG_OFF_BIT],
				acmp_pkg::PIN_OFF_RESET[acmp_pkg::PIN_POS_OFF_BIT]};
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		axil_rsp.awready = st_reg.aw_rdy;
		axil_rsp.wready = st_reg.w_rdy;
		axil_rsp.bvalid = st_reg.bvalid;
		axil_rsp.bresp = st_reg.bresp;
		axil_rsp.arready = st_reg.ar_rdy;
		axil_rsp.rvalid = st_reg.rvalid;
		axil_rsp.rresp = st_reg.rresp;
		axil_rsp.rdata = {24'h000000, st_reg.rbyte};
	end

	assign compare_irq = st_reg.irq;
	assign capture_trigger = st_reg.capture;
	assign pin_read_value = st_reg.pin_read;
	assign pin_buffer_enable = st_reg.buf_en;
	assign comparator_power_on = st_reg.pwr_on;
	assign bandgap_select = st_reg.bg_sel;
	assign negative_mux_enable = st_reg.mux_en;
	assign trigger_source_select = st_reg.trig_sel;
endmodule // acmp_ctrl
`default_nettype wire

// [testbench/acmp_ctrl_sva.sv]
// port assertions of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acmp_ctrl_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire acmp_pkg::acmp_axil_req_t axil_req,
	input wire acmp_pkg::acmp_axil_rsp_t axil_rsp,
	input wire logic global_irq_enable,
	input wire logic [1:0] pin_digital_in,
	input wire logic compare_irq,
	input wire logic capture_trigger,
	input wire logic [1:0] pin_read_value,
	input wire logic [1:0] pin_buffer_enable,
	input wire logic comparator_power_on,
	input wire logic negative_mux_enable,
	input wire logic [acmp_pkg::TRIG_W-1:0] trigger_source_select
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
	endsequence
	sequence rd_taken;
		axil_req.arvalid && axil_rsp.arready;
	endsequence
	a_write_answer: assert property (wr_taken |=> !axil_rsp.bvalid ##1 axil_rsp.bvalid)
		else $error("write answer not on time");
	a_read_answer: assert property (rd_taken |=> axil_rsp.rvalid && !axil_rsp.arready)
		else $error("read answer not on time");
	a_bresp_held: assert property (axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid)
		else $error("write answer dropped early");
	a_rdata_held: assert property (axil_rsp.rvalid && !axil_req.rready |=> $stable(axil_rsp.rdata))
		else $error("read data changed while pending");
	a_ctrlb_readback: assert property (rd_taken ##0 axil_req.araddr[11:2] == {2'h0, acmp_pkg::IDX_ADC_CTRL_B}
		|=> axil_rsp.rdata == {25'h0, $past(negative_mux_enable), 3'h0, $past(trigger_source_select)})
		else $error("converter control readback wrong");
	a_irq_global: assert property (compare_irq |-> $past(global_irq_enable))
		else $error("irq without global enable");
	a_pin_on_follow: assert property ($past(aresetn) |->
		((pin_read_value ^ $past(pin_digital_in)) & pin_buffer_enable & $past(pin_buffer_enable)) == 2'h0)
		else $error("pin read does not follow pin");
	a_pin_off_zero: assert property ((pin_read_value & ~pin_buffer_enable & ~$past(pin_buffer_enable)) == 2'h0)
		else $error("disabled pin reads one");
	a_power_quiet: assert property (!comparator_power_on [*4] |=> !capture_trigger)
		else $error("capture active while powered off");
endmodule // acmp_ctrl_sva
bind acmp_ctrl acmp_ctrl_sva u_sva (
	.aclk(aclk),
	.aresetn(aresetn),
	.axil_req(axil_req),
	.axil_rsp(axil_rsp),
	.global_irq_enable(global_irq_enable),
	.pin_digital_in(pin_digital_in),
	.compare_irq(compare_irq),
	.capture_trigger(capture_trigger),
	.pin_read_value(pin_read_value),
	.pin_buffer_enable(pin_buffer_enable),
	.comparator_power_on(comparator_power_on),
	.negative_mux_enable(negative_mux_enable),
	.trigger_source_select(trigger_source_select)
);
`default_nettype wire

// [testbench/acmp_pins_model.sv]
// far side model: analog pin levels, digital pins, timer capture front end
`timescale 1ns/1ps
`default_nettype none
module acmp_pins_model #(
	parameter int LEVEL_W = 10
) (
	input wire logic aclk,
	input wire logic capture_trigger,
	output logic [LEVEL_W-1:0] positive_compare_pin,
	output logic [LEVEL_W-1:0] negative_compare_pin,
	output logic [acmp_pkg::CONV_PINS*LEVEL_W-1:0] converter_pins,
	output logic [1:0] pin_digital_in
);
	logic trig_q = 1'b0;
	logic timer_capture_irq_enable = 1'b1;
	logic capture_irq = 1'b0;
	int capture_edges = 0;
	initial begin
		positive_compare_pin = '0;
		negative_compare_pin = '0;
		converter_pins = '0;
		pin_digital_in = '0;
	end
	// rising edge selection of the capture front end
	always @(posedge aclk) begin
		trig_q <= capture_trigger;
		if (capture_trigger && !trig_q) begin
			capture_edges <= capture_edges + 1;
		end
		capture_irq <= capture_trigger && !trig_q && timer_capture_irq_enable;
	end
	task automatic drive(input logic [LEVEL_W-1:0] p, n, input logic [acmp_pkg::CONV_PINS*LEVEL_W-1:0] c,
		input logic [1:0] d);
		@(posedge aclk);
		positive_compare_pin <= p;
		negative_compare_pin <= n;
		converter_pins <= c;
		pin_digital_in <= d;
	endtask
endmodule // acmp_pins_model
`default_nettype wire

// [testbench/tb_analog_comparator_control.sv]
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_analog_comparator_control;
	localparam logic [11:0] A_B = {2'h0, acmp_pkg::IDX_ADC_CTRL_B, 2'h0};
	localparam logic [11:0] A_C = {2'h0, acmp_pkg::IDX_CMP_CTRL, 2'h0};
	localparam logic [11:0] A_P = {2'h0, acmp_pkg::IDX_PIN_OFF, 2'h0};
	localparam logic [9:0] BG = 10'h1FF;
	logic aclk, aresetn, conv_en, gie, ack, irq, capt, pwr, bgs, mux;
	logic [2:0] chs, trig;
	acmp_pkg::acmp_axil_req_t req;
	acmp_pkg::acmp_axil_rsp_t rsp;
	logic [9:0] pos, neg;
	logic [79:0] conv;
	logic [1:0] din, rdv, bufen, resp;
	logic [31:0] rd;
	int num_errors, check_count, seed;
	acmp_pins_model pins (.aclk(aclk), .capture_trigger(capt), .positive_compare_pin(pos),
		.negative_compare_pin(neg), .converter_pins(conv), .pin_digital_in(din));
	acmp_ctrl #(.LEVEL_W(10), .BANDGAP_LEVEL(BG)) dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
		.axil_rsp(rsp), .positive_compare_pin(pos), .negative_compare_pin(neg), .converter_pins(conv),
		.converter_enable(conv_en), .channel_select_low(chs), .global_irq_enable(gie), .irq_vector_ack(ack),
		.pin_digital_in(din), .compare_irq(irq), .capture_trigger(capt), .pin_read_value(rdv),
		.pin_buffer_enable(bufen), .comparator_power_on(pwr), .bandgap_select(bgs),
		.negative_mux_enable(mux), .trigger_source_select(trig));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic aw, w;
		@(posedge aclk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		aw = 0;
		w = 0;
		n = 0;
		while (!(aw && w) && n < 50) begin
			@(posedge aclk);
			n++;
			if (rsp.awready) aw = 1;
			if (rsp.wready) w = 1;
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end
		do begin
			@(posedge aclk);
			n++;
		end while (!rsp.bvalid && n < 50);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 50) num_errors++;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		int n;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rsp.arready && n < 50);
		req.arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rsp.rvalid && n < 50);
		rd = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 50) num_errors++;
		check(rd, e);
	endtask
	function automatic logic exp_res(input logic [9:0] p, n, input logic [79:0] c, input logic b, m, e,
		input logic [2:0] ch);
		logic [9:0] pp, nn;
		pp = b ? BG : p;
		nn = (m && !e) ? c[ch*10 +: 10] : n;
		return pp > nn;
	endfunction
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		#2000000;
		num_errors++;
		summarize();
	end
	initial begin
		logic [9:0] p, n;
		logic [79:0] c;
		logic b, m, e, x, fr;
		logic [2:0] ch;
		logic [1:0] md, off;
		logic [7:0] v;
		aresetn = 1'b0;
		conv_en = 1'b0;
		gie = 1'b0;
		ack = 1'b0;
		chs = 3'h0;
		req = '0;
		req.wstrb = 4'hF;
		seed = $urandom(36);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(A_B, 32'h0);
		rchk(A_C, 32'h0);
		rchk(A_P, 32'h0);
		check({30'h0, bufen}, 32'h3);
		check({31'h0, pwr}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(A_B, v);
			check({28'h0, mux, trig}, {28'h0, v[6], v[2:0]});
			rchk(A_B, {24'h0, v & 8'h47});
		end
		wr(12'h004, 8'hFF);
		check({30'h0, resp}, {30'h0, acmp_pkg::RESP_DECERR});
		rchk(12'h004, 32'h0);
		for (int i = 0; i < 16; i++) begin
			p = 10'($urandom);
			n = 10'($urandom);
			c = 80'({$urandom, $urandom, $urandom});
			{b, m, e, ch} = 6'($urandom);
			if (i < 8) begin
				{ch, m, e, b, p, c} = {3'(i), 3'b100, 10'h200, 80'h0};
				c[i*10 +: 10] = 10'h3FF;
			end
			if (i == 8) {b, m, n} = {2'b00, p};
			conv_en <= e;
			chs <= ch;
			wr(A_B, {1'b0, m, 6'h0});
			wr(A_C, {1'b0, b, 6'h1});
			check({31'h0, bgs}, {31'h0, b});
			pins.drive(p, n, c, 2'($urandom));
			cyc(4);
			rchk(A_C, {24'h0, 1'b0, b, exp_res(p, n, c, b, m, e, ch), 5'h1});
		end
		wr(A_B, 8'h00);
		wr(A_C, 8'h81);
		pins.drive(10'h300, 10'h100, '0, 2'h0);
		cyc(4);
		check({31'h0, pwr}, 32'h0);
		rchk(A_C, 32'h81);
		wr(A_C, 8'h01);
		cyc(4);
		rchk(A_C, 32'h21);
		for (int k = 0; k < 4; k++) begin
			md = 2'(k);
			x = (k == 3) ? 1'b1 : 1'($urandom);
			wr(A_C, {6'h0, md});
			pins.drive(10'h100, 10'h300, '0, 2'h0);
			cyc(5);
			wr(A_C, {6'h4, md});
			pins.drive(10'h300, 10'h100, '0, 2'h0);
			cyc(5);
			fr = (md == acmp_pkg::MODE_TOGGLE) || (md == acmp_pkg::MODE_RISE);
			rchk(A_C, {27'h1, fr, 2'h0, md});
			check({31'h0, irq}, 32'h0);
			gie <= x;
			wr(A_C, {6'h2, md});
			check({31'h0, irq}, {31'h0, fr & x});
			rchk(A_C, {27'h1, fr, 2'h2, md});
			ack <= 1'b1;
			@(posedge aclk);
			ack <= 1'b0;
			cyc(2);
			check({31'h0, irq}, 32'h0);
			rchk(A_C, {27'h1, 3'h2, md});
			wr(A_C, {6'h0, md});
			pins.drive(10'h100, 10'h300, '0, 2'h0);
			cyc(5);
			fr = (md == acmp_pkg::MODE_TOGGLE) || (md == acmp_pkg::MODE_FALL);
			rchk(A_C, {27'h0, fr, 2'h0, md});
		end
		wr(A_C, 8'h05);
		for (int i = 0; i < 3; i++) begin
			pins.drive(10'h300, 10'h100, '0, 2'h0);
			cyc(4);
			check({31'h0, capt}, 32'h1);
			pins.drive(10'h100, 10'h300, '0, 2'h0);
			cyc(4);
			check({31'h0, capt}, 32'h0);
		end
		check(32'(pins.capture_edges), 32'h3);
		wr(A_C, 8'h01);
		pins.drive(10'h300, 10'h100, '0, 2'h0);
		cyc(4);
		check({31'h0, capt}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			off = (i == 0) ? 2'h3 : 2'($urandom);
			v = 8'($urandom);
			wr(A_P, {6'h0, off});
			pins.drive(10'h100, 10'h300, '0, v[1:0]);
			cyc(2);
			check({30'h0, rdv}, {30'h0, v[1:0] & ~off});
			check({30'h0, bufen}, {30'h0, ~off});
		end
		summarize();
	end
endmodule // tb_analog_comparator_control
`default_nettype wire
